// ==== src/asc_pkg.sv ====
// Constants and types shared by the asynchronous serial channel
package asc_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [3:0] IDX_DATA = 4'h0;
	localparam logic [3:0] IDX_IER = 4'h1;
	localparam logic [3:0] IDX_IIR = 4'h2;
	localparam logic [3:0] IDX_LCR = 4'h3;
	localparam logic [3:0] IDX_MCR = 4'h4;
	localparam logic [3:0] IDX_LSR = 4'h5;
	localparam logic [3:0] IDX_MSR = 4'h6;
	localparam logic [3:0] IDX_SCR = 4'h7;
	localparam logic [3:0] IDX_IST = 4'h8;
	localparam logic [3:0] IDX_ICLR = 4'h9;
	localparam logic [3:0] IDX_IEN = 4'ha;
	// Values after reset
	localparam logic [15:0] DIV_RST = 16'h000c;
	localparam logic [7:0] LCR_RST = 8'h00;
	localparam logic [4:0] MCR_RST = 5'h00;
	localparam logic [3:0] IER_RST = 4'h0;
	localparam logic [7:0] SCR_RST = 8'h00;
	// Line and modem control field positions
	localparam int LCR_STB = 2;
	localparam int LCR_PEN = 3;
	localparam int LCR_EPS = 4;
	localparam int LCR_STICK = 5;
	localparam int LCR_BRK = 6;
	localparam int LCR_DIVISOR_ACCESS = 7;
	localparam int MCR_LOOP = 4;
	// Oversampling counts, in 16x ticks
	localparam logic [5:0] BIT_TICKS = 6'h10;
	localparam logic [5:0] STOP15_TICKS = 6'h18;
	localparam logic [5:0] STOP2_TICKS = 6'h20;
	localparam logic [3:0] MID_TICK = 4'h7;
	localparam logic [3:0] LAST_TICK = 4'hf;
	// Identification codes, priority order
	localparam logic [7:0] IIR_NONE = 8'h01;
	localparam logic [7:0] IIR_LINE = 8'h06;
	localparam logic [7:0] IIR_RXD = 8'h04;
	localparam logic [7:0] IIR_TX_HOLDING_EMPTY = 8'h02;
	localparam logic [7:0] IIR_MODEM = 8'h00;
	typedef enum logic [4:0] {
		TX_IDLE = 5'b00001,
		TX_START = 5'b00010,
		TX_DATA = 5'b00100,
		TX_PAR = 5'b01000,
		TX_STOP = 5'b10000
	} asc_tx_st_t;
	typedef enum logic [4:0] {
		RX_IDLE = 5'b00001,
		RX_START = 5'b00010,
		RX_DATA = 5'b00100,
		RX_PAR = 5'b01000,
		RX_STOP = 5'b10000
	} asc_rx_st_t;
endpackage : asc_pkg

// ==== src/asc_serial_channel.sv ====
// Asynchronous serial channel with AHB-Lite register slave
// Function
// - Frame: start, 5-8 data, parity, stop
// - Long stop: 1.5 for 5-bit, else 2
// - Divisor 1..65535 makes 16x transmit clock
// - Receiver also timed by 16x clock
// - Offset 0: read rx_buffer, write tx_holding
// - Divisor access maps offsets 0,1 to divisor
// - irq_enable bits 0-3 select four sources
// - irq_ident: bit0 low pending, code bits 1-2
// - Length bits: 00 five to 11 eight
// - Stop count, parity, even, stick, break bits
// - line_control bit 7 is divisor access
// - modem_control drives DTR RTS OUT1 OUT2 loop
// - line_status bits 0-4 receive status
// - Bits 5,6 holding and shifter empty
// - modem_status bits 0-3 change flags
// - modem_status bits 4-7 current levels
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module asc_serial_channel
	import asc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Serial line and modem pins
	input wire logic rxd,
	input wire logic cts,
	input wire logic dsr,
	input wire logic ri,
	input wire logic dcd,
	output logic txd,
	output logic dtr,
	output logic rts,
	output logic out1,
	output logic out2,
	// Interrupt
	output logic irq
);
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [4:0] pin_q1_r, pin_q2_r;
	logic ap_ok, rd_ap, wr_dp_r;
	logic [3:0] idx, wr_idx_r;
	logic [7:0] wd, rd_val, iir_val;
	logic [15:0] div_r;
	logic [15:0] bcnt_r;
	logic tick;
	logic [7:0] lcr_r, scr_r, thr_r, tsh_r, rbr_r, rsh_r;
	logic [4:0] mcr_r;
	logic [3:0] ier_r, ist_r, ien_r, lvl, lvl_prev_r, delta_r;
	logic thr_full_r, tx_holding_empty_irq_r, dr_r, oe_r, pe_r, fe_r, bi_r;
	logic loop, divisor_access, rx_in, tx_bit, txd_r, rx_done, tsr_load, ms_set, le_set;
	logic [3:0] ev;
	logic [5:0] tcnt_r, stop_len;
	logic [2:0] tbit_r, rbit_r, last_bit;
	logic [3:0] rcnt_r;
	logic rpar_r;
	asc_tx_st_t tx_st_r;
	asc_rx_st_t rx_st_r;

	// Parity bit for the active length, shared by both directions
	function automatic logic par_bit(input logic [7:0] d, input logic [7:0] l);
		logic [7:0] m;
		m = d & (8'hff >> (2'd3 - l[1:0]));
		if (l[LCR_STICK])
			par_bit = ~l[LCR_EPS];
		else
			par_bit = l[LCR_EPS] ? ^m : ~^m;
	endfunction : par_bit

	// Reset release through two flops
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// Pin synchronisers; only the second stage is read
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		// Reset to idle levels (line high, modem lines off) so no false change follows reset
		if (!rst_n)
		begin
			pin_q1_r <= 5'h10;
			pin_q2_r <= 5'h10;
		end
		else
		begin
			pin_q1_r <= {rxd, dcd, ri, dsr, cts};
			pin_q2_r <= pin_q1_r;
		end
	end

	assign loop = mcr_r[MCR_LOOP];
	assign divisor_access = lcr_r[LCR_DIVISOR_ACCESS];
	// Loopback feeds transmit line and modem outputs back inside
	assign rx_in = loop ? txd_r : pin_q2_r[4];
	assign lvl = loop ? {mcr_r[3], mcr_r[2], mcr_r[0], mcr_r[1]} : pin_q2_r[3:0];
	assign last_bit = {1'b1, lcr_r[1:0]} - 3'd4 + 3'd4;
	assign stop_len = !lcr_r[LCR_STB] ? BIT_TICKS :
		(lcr_r[1:0] == 2'b00 ? STOP15_TICKS : STOP2_TICKS);

	// Bus decode; zero wait states, always OKAY
	assign ap_ok = hsel && htrans[1] && hready;
	assign rd_ap = ap_ok && !hwrite;
	assign idx = haddr[5:2];
	assign wd = hwdata[7:0];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_dp_r <= 1'b0;
			wr_idx_r <= 4'h0;
		end
		else
		begin
			wr_dp_r <= ap_ok && hwrite;
			wr_idx_r <= idx;
		end
	end

	// Identification code in fixed priority
	always_comb
	begin
		if (ier_r[2] && (oe_r || pe_r || fe_r || bi_r))
			iir_val = IIR_LINE;
		else if (ier_r[0] && dr_r)
			iir_val = IIR_RXD;
		else if (ier_r[1] && tx_holding_empty_irq_r)
			iir_val = IIR_TX_HOLDING_EMPTY;
		else if (ier_r[3] && |delta_r)
			iir_val = IIR_MODEM;
		else
			iir_val = IIR_NONE;
	end

	// Read mux, sampled in the address phase
	always_comb
	begin
		unique case (idx)
			IDX_DATA: rd_val = divisor_access ? div_r[7:0] : rbr_r;
			IDX_IER: rd_val = divisor_access ? div_r[15:8] : {4'h0, ier_r};
			IDX_IIR: rd_val = iir_val;
			IDX_LCR: rd_val = lcr_r;
			IDX_MCR: rd_val = {3'b000, mcr_r};
			IDX_LSR: rd_val = {1'b0, thr_full_r ? 1'b0 : tx_st_r == TX_IDLE, ~thr_full_r,
				bi_r, fe_r, pe_r, oe_r, dr_r};
			IDX_MSR: rd_val = {lvl[3], lvl[2], lvl[1], lvl[0], delta_r};
			IDX_SCR: rd_val = scr_r;
			IDX_IST: rd_val = {4'h0, ist_r};
			IDX_IEN: rd_val = {4'h0, ien_r};
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			hrdata <= 32'h0;
		else if (rd_ap)
			hrdata <= {24'h0, rd_val};
	end

	// Software control registers
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_r <= DIV_RST;
			ier_r <= IER_RST;
			lcr_r <= LCR_RST;
			mcr_r <= MCR_RST;
			scr_r <= SCR_RST;
			ien_r <= IER_RST;
		end
		else if (wr_dp_r)
		begin
			unique case (wr_idx_r)
				IDX_DATA: if (divisor_access) div_r[7:0] <= wd;
				IDX_IER: if (divisor_access) div_r[15:8] <= wd; else ier_r <= wd[3:0];
				IDX_LCR: lcr_r <= wd;
				IDX_MCR: mcr_r <= wd[4:0];
				IDX_SCR: scr_r <= wd;
				IDX_IEN: ien_r <= wd[3:0];
				default: ;
			endcase
		end
	end

	// Baud counter: one tick every divisor cycles; zero acts as one
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			bcnt_r <= 16'h0;
		else if (tick)
			bcnt_r <= 16'h0;
		else
			bcnt_r <= bcnt_r + 16'h1;
	end
	assign tick = (bcnt_r + 16'h1 >= div_r);

	// Holding register; a write wins over the shifter's load
	assign tsr_load = (tx_st_r == TX_IDLE) && thr_full_r;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			thr_r <= 8'h0;
			thr_full_r <= 1'b0;
			tx_holding_empty_irq_r <= 1'b0;
		end
		else
		begin
			if (wr_dp_r && wr_idx_r == IDX_DATA && !divisor_access)
			begin
				thr_r <= wd;
				thr_full_r <= 1'b1;
				tx_holding_empty_irq_r <= 1'b0;
			end
			else if (tsr_load)
			begin
				thr_full_r <= 1'b0;
				tx_holding_empty_irq_r <= 1'b1;
			end
			else if (rd_ap && idx == IDX_IIR && iir_val == IIR_TX_HOLDING_EMPTY)
				tx_holding_empty_irq_r <= 1'b0;
		end
	end

	// Transmit framer, stepping on 16x ticks
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_st_r <= TX_IDLE;
			tsh_r <= 8'h0;
			tcnt_r <= 6'h0;
			tbit_r <= 3'h0;
		end
		else
		begin
			unique case (tx_st_r)
				TX_IDLE: if (tsr_load)
				begin
					tsh_r <= thr_r;
					tcnt_r <= 6'h0;
					tbit_r <= 3'h0;
					tx_st_r <= TX_START;
				end
				TX_START, TX_DATA, TX_PAR: if (tick)
				begin
					tcnt_r <= tcnt_r + 6'h1;
					if (tcnt_r == BIT_TICKS - 6'h1)
					begin
						tcnt_r <= 6'h0;
						if (tx_st_r == TX_START)
							tx_st_r <= TX_DATA;
						else if (tx_st_r == TX_DATA && tbit_r != last_bit)
							tbit_r <= tbit_r + 3'h1;
						else if (tx_st_r == TX_DATA && lcr_r[LCR_PEN])
							tx_st_r <= TX_PAR;
						else
							tx_st_r <= TX_STOP;
					end
				end
				TX_STOP: if (tick)
				begin
					tcnt_r <= tcnt_r + 6'h1;
					if (tcnt_r == stop_len - 6'h1)
						tx_st_r <= TX_IDLE;
				end
			endcase
		end
	end

	// Line level for the current bit
	always_comb
	begin
		unique case (tx_st_r)
			TX_START: tx_bit = 1'b0;
			TX_DATA: tx_bit = tsh_r[tbit_r];
			TX_PAR: tx_bit = par_bit(tsh_r, lcr_r);
			default: tx_bit = 1'b1;
		endcase
	end

	// Pin outputs; in loopback the line idles and modem outputs drop
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txd_r <= 1'b1;
			txd <= 1'b1;
			{out2, out1, rts, dtr} <= 4'h0;
		end
		else
		begin
			txd_r <= tx_bit && !lcr_r[LCR_BRK];
			// Pin copy from its own flop; loopback holds the line at mark
			txd <= loop || (tx_bit && !lcr_r[LCR_BRK]);
			{out2, out1, rts, dtr} <= loop ? 4'h0 : mcr_r[3:0];
		end
	end

	// Receive framer, mid-bit sampling on 16x ticks
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_st_r <= RX_IDLE;
			rcnt_r <= 4'h0;
			rbit_r <= 3'h0;
			rsh_r <= 8'h0;
			rpar_r <= 1'b0;
		end
		else if (rx_st_r == RX_IDLE)
		begin
			rcnt_r <= 4'h0;
			if (!rx_in)
				rx_st_r <= RX_START;
		end
		else if (tick)
		begin
			rcnt_r <= rcnt_r + 4'h1;
			unique case (rx_st_r)
				RX_START: if (rcnt_r == MID_TICK)
				begin
					rcnt_r <= 4'h0;
					rbit_r <= 3'h0;
					rsh_r <= 8'h0;
					rx_st_r <= rx_in ? RX_IDLE : RX_DATA;
				end
				RX_DATA: if (rcnt_r == LAST_TICK)
				begin
					rsh_r[rbit_r] <= rx_in;
					rbit_r <= rbit_r + 3'h1;
					if (rbit_r == last_bit)
						rx_st_r <= lcr_r[LCR_PEN] ? RX_PAR : RX_STOP;
				end
				RX_PAR: if (rcnt_r == LAST_TICK)
				begin
					rpar_r <= rx_in;
					rx_st_r <= RX_STOP;
				end
				RX_STOP: if (rcnt_r == LAST_TICK)
					rx_st_r <= RX_IDLE;
				default: rx_st_r <= RX_IDLE;
			endcase
		end
	end
	assign rx_done = tick && rx_st_r == RX_STOP && rcnt_r == LAST_TICK;

	// Line status; a new byte or error wins over the read that clears it
	assign le_set = rx_done && (dr_r || !rx_in ||
		(lcr_r[LCR_PEN] && rpar_r != par_bit(rsh_r, lcr_r)));
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rbr_r <= 8'h0;
			{bi_r, fe_r, pe_r, oe_r, dr_r} <= 5'h0;
		end
		else
		begin
			if (rd_ap && idx == IDX_DATA && !divisor_access)
				dr_r <= 1'b0;
			if (rd_ap && idx == IDX_LSR)
				{bi_r, fe_r, pe_r, oe_r} <= 4'h0;
			if (rx_done)
			begin
				rbr_r <= rsh_r;
				dr_r <= 1'b1;
				if (dr_r)
					oe_r <= 1'b1;
				if (lcr_r[LCR_PEN] && rpar_r != par_bit(rsh_r, lcr_r))
					pe_r <= 1'b1;
				if (!rx_in)
					fe_r <= 1'b1;
				if (!rx_in && rsh_r == 8'h0 && !(lcr_r[LCR_PEN] && rpar_r))
					bi_r <= 1'b1;
			end
		end
	end

	// Modem change flags; a change wins over the clearing read
	assign ms_set = (lvl[0] != lvl_prev_r[0]) || (lvl[1] != lvl_prev_r[1]) ||
		(lvl_prev_r[2] && !lvl[2]) || (lvl[3] != lvl_prev_r[3]);
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lvl_prev_r <= 4'h0;
			delta_r <= 4'h0;
		end
		else
		begin
			lvl_prev_r <= lvl;
			delta_r <= (rd_ap && idx == IDX_MSR ? 4'h0 : delta_r) |
				{lvl[3] ^ lvl_prev_r[3], lvl_prev_r[2] & ~lvl[2],
				lvl[1] ^ lvl_prev_r[1], lvl[0] ^ lvl_prev_r[0]};
		end
	end

	// Sticky event bits, enable mask, level interrupt
	assign ev = {ms_set, le_set, tsr_load, rx_done};
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ist_r <= 4'h0;
			irq <= 1'b0;
		end
		else
		begin
			ist_r <= (wr_dp_r && wr_idx_r == IDX_ICLR ? ist_r & ~wd[3:0] : ist_r) | ev;
			irq <= |(ist_r & ien_r);
		end
	end

	// Checks
	property p_iir_pending;
		@(posedge sys_clk) disable iff (!rst_n)
		(ier_r[0] && dr_r) |-> (!iir_val[0] && iir_val[7:3] == 5'h0);
	endproperty
	a_iir_pending: assert property (p_iir_pending) else $error("iir not pending");
	property p_line_first;
		@(posedge sys_clk) disable iff (!rst_n)
		(ier_r[2] && oe_r) |-> iir_val == IIR_LINE;
	endproperty
	a_line_first: assert property (p_line_first) else $error("line status not first");
	property p_dr_set;
		@(posedge sys_clk) disable iff (!rst_n)
		rx_done |=> dr_r && rbr_r == $past(rsh_r);
	endproperty
	a_dr_set: assert property (p_dr_set) else $error("byte not delivered");
	property p_thr_write;
		@(posedge sys_clk) disable iff (!rst_n)
		(wr_dp_r && wr_idx_r == IDX_DATA && !divisor_access) |=> thr_full_r;
	endproperty
	a_thr_write: assert property (p_thr_write) else $error("holding not full");
	property p_tick_gap;
		@(posedge sys_clk) disable iff (!rst_n)
		(tick && div_r == 16'h3 && $stable(div_r)) |=> !tick [*2] ##1 tick;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("baud period wrong");
	property p_break;
		@(posedge sys_clk) disable iff (!rst_n)
		(lcr_r[LCR_BRK] && !loop) |=> !txd;
	endproperty
	a_break: assert property (p_break) else $error("break not driven");
	property p_loop;
		@(posedge sys_clk) disable iff (!rst_n)
		loop |=> txd && !dtr && !rts;
	endproperty
	a_loop: assert property (p_loop) else $error("loop leaks to pins");
	property p_div_read;
		@(posedge sys_clk) disable iff (!rst_n)
		(rd_ap && idx == IDX_DATA && divisor_access) |=> hrdata[7:0] == $past(div_r[7:0]);
	endproperty
	a_div_read: assert property (p_div_read) else $error("divisor read wrong");
	property p_start_bit;
		@(posedge sys_clk) disable iff (!rst_n)
		(tx_st_r == TX_START && !lcr_r[LCR_BRK] && !loop) |=> !txd;
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("start bit not low");
	c_tx_frame: cover property (@(posedge sys_clk) tx_st_r == TX_STOP ##1 tx_st_r == TX_IDLE);
	c_rx_byte: cover property (@(posedge sys_clk) rx_done);
	c_overrun: cover property (@(posedge sys_clk) oe_r);
	c_irq: cover property (@(posedge sys_clk) $rose(irq));
endmodule : asc_serial_channel
`default_nettype wire

// ==== tb/asc_term.sv ====
// Serial terminal model on the line and modem pins
`timescale 1ns/10ps
`default_nettype none
module asc_term #(
	parameter int BIT_CYC = 16
)
(
	// Clock
	input wire logic sys_clk,
	// Serial line
	input wire logic txd,
	output logic rxd,
	// Modem levels
	output logic cts,
	output logic dsr,
	output logic ri,
	output logic dcd,
	// Bits to capture per frame
	input wire logic [3:0] rx_len
);
	int cyc = 0;
	int t0 = 0;
	int period = 0;
	int frames = 0;
	logic [11:0] frame = 12'h000;
	// Idle mark level, modem lines off
	initial
	begin
		rxd = 1'b1;
		{cts, dsr, ri, dcd} = 4'h0;
	end
	// Cycle count for frame spacing
	always @(posedge sys_clk)
		cyc <= cyc + 1;
	// Capture mid-bit; start-to-start spacing exposes stop length
	always
	begin
		@(negedge txd);
		period = cyc - t0;
		t0 = cyc;
		frame = 12'h000;
		for (int i = 0; i < rx_len; i++)
		begin
			repeat ((i == 0) ? BIT_CYC / 2 : BIT_CYC) @(posedge sys_clk);
			frame[i] = txd;
		end
		frames++;
	end
	// Send LSB first, then back to idle mark
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge sys_clk);
			rxd <= bits[i];
			repeat (BIT_CYC - 1) @(posedge sys_clk);
		end
		@(posedge sys_clk);
		rxd <= 1'b1;
	endtask : send
	// Modem levels in order cts, dsr, ri, dcd
	task automatic modem(input logic [3:0] lv);
		@(posedge sys_clk);
		{cts, dsr, ri, dcd} <= lv;
	endtask : modem
endmodule : asc_term
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the serial channel
`timescale 1ns/10ps
`default_nettype none
module tb
	import asc_pkg::*;
;
	typedef struct {logic w; logic [3:0] ix; logic [7:0] wd; logic [7:0] ex;} asc_row_t;
	typedef struct {logic [7:0] line_control; logic [7:0] d; logic [11:0] frm; logic [3:0] n; int per;} asc_fmt_t;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready, hresp, rxd, cts, dsr, ri, dcd, txd, dtr, rts, out1, out2, irq;
	logic [3:0] rx_len = 4'ha;
	logic [7:0] rd = 8'h00;
	int fail_count = 0;
	int cmp_count = 0;
	int n;
	// Write then read back; divisor 1 keeps a bit at 16 cycles
	asc_row_t rows [11] = '{
		'{1'b1, IDX_SCR, 8'ha5, 8'ha5},
		'{1'b1, 4'hb, 8'h55, 8'h00},
		'{1'b1, IDX_LCR, 8'h80, 8'h80},
		'{1'b0, IDX_DATA, 8'h00, 8'h0c},
		'{1'b1, IDX_DATA, 8'h01, 8'h01},
		'{1'b1, IDX_IER, 8'h00, 8'h00},
		'{1'b1, IDX_LCR, 8'h03, 8'h03},
		'{1'b1, IDX_IER, 8'h05, 8'h05},
		'{1'b1, IDX_IEN, 8'h01, 8'h01},
		'{1'b1, IDX_MCR, 8'h0f, 8'h0f},
		'{1'b1, IDX_SCR, 8'h5a, 8'h5a}
	};
	// Formats 8N1, 5E with long stop, 7O2, 6N1, 8 with stick parity high
	asc_fmt_t fmts [5] = '{
		'{8'h03, 8'h5a, 12'h2b4, 4'ha, 160},
		'{8'h1c, 8'h16, 12'h0ec, 4'h8, 136},
		'{8'h0e, 8'h41, 12'h382, 4'ha, 176},
		'{8'h01, 8'h2a, 12'h0d4, 4'h8, 128},
		'{8'h2b, 8'h01, 12'h602, 4'hb, 176}
	};
	// Index and value after reset
	logic [11:0] rst_rows [8] = '{{IDX_IER, 8'h00}, {IDX_IIR, IIR_NONE}, {IDX_LCR, 8'h00},
		{IDX_MCR, 8'h00}, {IDX_LSR, 8'h60}, {IDX_SCR, 8'h00}, {IDX_IEN, 8'h00}, {IDX_IST, 8'h00}};

	// Clock
	always #25 sys_clk = ~sys_clk;

	// Design and terminal
	asc_serial_channel asc_serial_channel_i (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .rxd(rxd),
		.cts(cts), .dsr(dsr), .ri(ri), .dcd(dcd), .txd(txd), .dtr(dtr), .rts(rts),
		.out1(out1), .out2(out2), .irq(irq));
	asc_term asc_term_i (.sys_clk(sys_clk), .txd(txd), .rxd(rxd), .cts(cts), .dsr(dsr),
		.ri(ri), .dcd(dcd), .rx_len(rx_len));

	task automatic chk(input logic [15:0] got, input logic [15:0] ex);
		cmp_count++;
		if (got !== ex)
		begin
			fail_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, ex);
		end
	endtask : chk

	// One AHB single transfer; waits on hready, never on a fixed count
	task automatic bus(input logic w, input logic [3:0] ix, input logic [7:0] wd);
		htrans <= 2'h2;
		haddr <= {26'h0, ix, 2'h0};
		hwrite <= w;
		@(posedge sys_clk);
		while (hready !== 1'b1) @(posedge sys_clk);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		@(posedge sys_clk);
		while (hready !== 1'b1) @(posedge sys_clk);
		rd = hrdata[7:0];
	endtask : bus

	task automatic rdc(input logic [3:0] ix, input logic [7:0] ex);
		bus(1'b0, ix, 8'h00);
		chk({8'h00, rd}, {8'h00, ex});
	endtask : rdc

	// Sticky status has no read side effect, so poll it
	task automatic wait_dr();
		do
			bus(1'b0, IDX_IST, 8'h00);
		while (rd[0] !== 1'b1);
	endtask : wait_dr

	// Two-flop sync plus register stage fits in six cycles
	task automatic modem_status(input logic [3:0] lv, input logic [7:0] ex);
		asc_term_i.modem(lv);
		repeat (6) @(posedge sys_clk);
		rdc(IDX_MSR, ex);
	endtask : modem_status

	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done

	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	// Watchdog, far beyond the few thousand cycles expected
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		$display("watchdog expired");
		end_sim();
	end

	// Main sequence
	initial
	begin
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		foreach (rows[i])
		begin
			if (rows[i].w)
				bus(1'b1, rows[i].ix, rows[i].wd);
			rdc(rows[i].ix, rows[i].ex);
		end
		done("registers");
		chk({11'h000, hresp, dtr, rts, out1, out2}, 16'h000f);
		modem_status(4'h8, 8'h11);
		rdc(IDX_MSR, 8'h10);
		modem_status(4'ha, 8'h50);
		modem_status(4'h8, 8'h14);
		modem_status(4'h5, 8'hab);
		modem_status(4'h0, 8'h0a);
		done("modem");
		bus(1'b1, IDX_ICLR, 8'h0f);
		foreach (fmts[i])
		begin
			bus(1'b1, IDX_LCR, fmts[i].line_control);
			rx_len <= fmts[i].n;
			n = asc_term_i.frames;
			bus(1'b1, IDX_DATA, fmts[i].d);
			repeat (2) @(posedge sys_clk);
			rdc(IDX_LSR, 8'h20);
			bus(1'b1, IDX_DATA, fmts[i].d);
			rdc(IDX_LSR, 8'h00);
			while (asc_term_i.frames < n + 2) @(posedge sys_clk);
			chk({4'h0, asc_term_i.frame}, {4'h0, fmts[i].frm});
			chk({15'h0, (asc_term_i.period - fmts[i].per) inside {[0:3]}}, 16'h0001);
			repeat (40) @(posedge sys_clk);
			rdc(IDX_LSR, 8'h60);
		end
		done("transmit");
		bus(1'b1, IDX_LCR, 8'h43);
		repeat (2) @(posedge sys_clk);
		chk({15'h0, txd}, 16'h0000);
		bus(1'b1, IDX_LCR, 8'h03);
		repeat (2) @(posedge sys_clk);
		chk({15'h0, txd}, 16'h0001);
		done("break");
		bus(1'b1, IDX_ICLR, 8'h0f);
		asc_term_i.send(12'h386, 10);
		wait_dr();
		repeat (2) @(posedge sys_clk);
		chk({15'h0, irq}, 16'h0001);
		rdc(IDX_IIR, IIR_RXD);
		rdc(IDX_DATA, 8'hc3);
		rdc(IDX_IIR, IIR_NONE);
		bus(1'b1, IDX_ICLR, 8'h01);
		repeat (2) @(posedge sys_clk);
		chk({15'h0, irq}, 16'h0000);
		done("receive");
		bus(1'b1, IDX_IEN, 8'h00);
		bus(1'b1, IDX_LCR, 8'h1b);
		asc_term_i.send(12'h002, 11);
		wait_dr();
		chk({15'h0, irq}, 16'h0000);
		rdc(IDX_IIR, IIR_LINE);
		rdc(IDX_IST, 8'h05);
		rdc(IDX_LSR, 8'h6d);
		rdc(IDX_LSR, 8'h61);
		asc_term_i.send(12'h700, 11);
		repeat (8) @(posedge sys_clk);
		rdc(IDX_LSR, 8'h63);
		rdc(IDX_DATA, 8'h80);
		done("errors");
		bus(1'b1, IDX_ICLR, 8'h01);
		bus(1'b1, IDX_MCR, 8'h1f);
		bus(1'b1, IDX_DATA, 8'h5a);
		wait_dr();
		chk({11'h000, txd, dtr, rts, out1, out2}, 16'h0010);
		rdc(IDX_DATA, 8'h5a);
		rdc(IDX_MSR, 8'hfb);
		done("loopback");
		bus(1'b1, IDX_LCR, 8'h80);
		bus(1'b1, IDX_DATA, 8'h03);
		repeat (12) @(posedge sys_clk);
		rdc(IDX_DATA, 8'h03);
		done("divisor");
		@(posedge sys_clk);
		nrst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk({10'h0, txd, dtr, rts, out1, out2, irq}, 16'h0020);
		nrst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		foreach (rst_rows[i])
			rdc(rst_rows[i][11:8], rst_rows[i][7:0]);
		done("reset");
		end_sim();
	end
endmodule : tb
`default_nettype wire
